// ===== design/arith_regs.svh
`ifndef ARITH_REGS_SVH
`define ARITH_REGS_SVH

`define APB_AW 12
`define REG_CTRL 12'h000
`define REG_SRC_A 12'h004
`define REG_SRC_B 12'h008
`define REG_DST 12'h00c
`define REG_FLAGS 12'h010
`define REG_STATUS 12'h014
`define REG_IRQ_STAT 12'h018
`define REG_IRQ_MASK 12'h01c
`define REG_MEM_ADDR 12'h020
`define REG_MEM_DATA 12'h024

`define CTRL_COND_BIT 2
`define CTRL_GO_BIT 8
`define FLAGS_CARRY_BIT 0
`define IRQ_DONE_BIT 0
`define IRQ_ERR_BIT 1

`define DM_DEPTH_DEF 1024
`define DM_DEPTH_MAX 10000

`endif

// ===== design/arith_pkg.sv
package arith_pkg;

  typedef enum logic [1:0] {
    word_add_op,
    word_subtract_op,
    word_multiply_op,
    word_divide_op
  } op_t;

  typedef enum logic [2:0] {
    st_idle,
    st_ptr,
    st_pchk,
    st_rda,
    st_rdb,
    st_capb,
    st_exec,
    st_wr2
  } seq_t;

  // ctrl bits [5:0]: ind_r ind_b ind_a cond op[1:0]
  typedef struct packed {
    logic ind_r;
    logic ind_b;
    logic ind_a;
    logic cond;
    op_t op;
  } cfg_t;

  // flags bits [5:0]
  typedef struct packed {
    logic error_flag;
    logic signed_underflow_flag;
    logic signed_overflow_flag;
    logic negative_flag;
    logic zero_result_flag;
    logic carry_flag;
  } flags_t;

  typedef struct packed {
    seq_t st;
    logic [1:0] idx;
    cfg_t cfg;
    logic [15:0] adr_a, adr_b, adr_r, a, b, hi, mem_addr;
    flags_t flg;
    logic [1:0] irq_st, irq_mask;
    logic [31:0] prdata;
    logic pready, pslverr, irq, busy;
  } unit_state_t;

endpackage

// ===== design/word_mem.sv
`timescale 1ns/1ps
`default_nettype none

module word_mem #(
  parameter int DEPTH = 1024,
  parameter int WIDTH = 16
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_we,
  input wire logic [$clog2(DEPTH)-1:0] i_addr,
  input wire logic [WIDTH-1:0] i_wdata,
  output logic [WIDTH-1:0] o_rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  // read-before-write: a write shows up on the next read only
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
    if (!i_rstn) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= mem[i_addr];
    end
  end

endmodule

`default_nettype wire

// ===== design/binary_word_arith_unit.sv
// Summary of operation
// - condition false: no operation, results and flags untouched.
// - add writes low 16 bits of a+b+carry; carry when sum above ffff.
// - add/subtract set overflow when signed result exceeds +32767.
// - add/subtract set underflow when signed result below -32768.
// - zero flag set exactly when the stored result is zero.
// - add/subtract copy result bit 15 into negative flag.
// - error when indirect pointer is not bcd or beyond memory.
// - subtract stores a-b-carry, negative as two's complement.
// - subtract borrow set exactly when a below b plus carry.
// - unsigned multiply, low word then high word, bit 31 to negative.
// - unsigned divide, quotient to first word, remainder to next.
// - divide copies quotient bit 15 into negative flag.
//
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "arith_regs.svh"

module binary_word_arith_unit #(
  parameter int DEPTH = `DM_DEPTH_DEF
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [`APB_AW-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_irq,
  output logic o_busy
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [15:0] DEPTH_W = 16'(DEPTH);

  // pointers are four bcd digits, so more words could never be reached
  if (DEPTH < 2 || DEPTH > `DM_DEPTH_MAX) begin : g_depth_chk
    $error("word_mem depth out of range");
  end

  arith_pkg::unit_state_t q, d;
  logic mem_we;
  logic [15:0] mem_wa, mem_wd, mem_rd;
  logic ev_done, ev_err;

  function automatic logic bcd_ok(input logic [15:0] p);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (p[i*4 +: 4] > 4'h9) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  function automatic logic [15:0] bcd_val(input logic [15:0] p);
    return 16'(p[15:12]) * 16'd1000 + 16'(p[11:8]) * 16'd100
         + 16'(p[7:4]) * 16'd10 + 16'(p[3:0]);
  endfunction

  word_mem #(
    .DEPTH(DEPTH),
    .WIDTH(16)
  ) u_dm (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_we(mem_we),
    .i_addr(mem_wa[AW-1:0]),
    .i_wdata(mem_wd),
    .o_rdata(mem_rd)
  );

  always_comb begin
    logic [16:0] s17;
    logic [17:0] ss;
    logic [31:0] prod;
    logic [15:0] cur, quo, rem, lim, rdv;
    logic ind, fail, acc, wr, bad, busy;
    logic [1:0] w1c;
    d = q;
    mem_we = 1'b0;
    mem_wa = q.mem_addr;
    mem_wd = 16'h0000;
    ev_done = 1'b0;
    ev_err = 1'b0;
    s17 = 17'h00000;
    ss = 18'h00000;
    prod = 32'h00000000;
    quo = 16'h0000;
    rem = 16'h0000;
    rdv = 16'h0000;
    fail = 1'b0;
    bad = 1'b0;
    w1c = 2'h0;
    busy = (q.st != arith_pkg::st_idle);
    acc = i_psel && i_penable;
    wr = acc && q.pready && i_pwrite && !q.pslverr;
    cur = q.adr_a;
    ind = q.cfg.ind_a;
    case (q.idx)
      2'd1: begin
        cur = q.adr_b;
        ind = q.cfg.ind_b;
      end
      2'd2: begin
        cur = q.adr_r;
        ind = q.cfg.ind_r;
      end
      default: begin
      end
    endcase
    lim = (q.cfg.op == arith_pkg::word_multiply_op || q.cfg.op == arith_pkg::word_divide_op)
        ? DEPTH_W - 16'h0001 : DEPTH_W;

    case (q.st)
      arith_pkg::st_ptr: begin
        mem_wa = cur;
        if (q.idx == 2'd3) begin
          d.st = arith_pkg::st_rda;
        end else if (!ind) begin
          d.idx = q.idx + 2'd1;
        end else if (cur >= DEPTH_W) begin
          fail = 1'b1;
        end else begin
          d.st = arith_pkg::st_pchk;
        end
      end
      arith_pkg::st_pchk: begin
        if (!bcd_ok(mem_rd) || bcd_val(mem_rd) >= DEPTH_W) begin
          fail = 1'b1;
        end else begin
          case (q.idx)
            2'd0: d.adr_a = bcd_val(mem_rd);
            2'd1: d.adr_b = bcd_val(mem_rd);
            default: d.adr_r = bcd_val(mem_rd);
          endcase
          d.idx = q.idx + 2'd1;
          d.st = arith_pkg::st_ptr;
        end
      end
      arith_pkg::st_rda: begin
        mem_wa = q.adr_a;
        // a result pair must not run past the last word
        if (q.adr_a >= DEPTH_W || q.adr_b >= DEPTH_W || q.adr_r >= lim) begin
          fail = 1'b1;
        end else begin
          d.st = arith_pkg::st_rdb;
        end
      end
      arith_pkg::st_rdb: begin
        mem_wa = q.adr_b;
        d.a = mem_rd;
        d.st = arith_pkg::st_capb;
      end
      arith_pkg::st_capb: begin
        d.b = mem_rd;
        d.st = arith_pkg::st_exec;
      end
      arith_pkg::st_exec: begin
        mem_wa = q.adr_r;
        d.st = arith_pkg::st_idle;
        case (q.cfg.op)
          arith_pkg::word_add_op: begin
            s17 = {1'b0, q.a} + {1'b0, q.b} + {16'h0000, q.flg.carry_flag};
            ss = {{2{q.a[15]}}, q.a} + {{2{q.b[15]}}, q.b} + {17'h00000, q.flg.carry_flag};
            d.flg.carry_flag = s17[16];
          end
          arith_pkg::word_subtract_op: begin
            s17 = {1'b0, q.a} - {1'b0, q.b} - {16'h0000, q.flg.carry_flag};
            ss = {{2{q.a[15]}}, q.a} - {{2{q.b[15]}}, q.b} - {17'h00000, q.flg.carry_flag};
            d.flg.carry_flag = s17[16];
          end
          arith_pkg::word_multiply_op: begin
            prod = {16'h0000, q.a} * {16'h0000, q.b};
            mem_we = 1'b1;
            mem_wd = prod[15:0];
            d.hi = prod[31:16];
            d.flg.zero_result_flag = (prod == 32'h00000000);
            d.flg.negative_flag = prod[31];
            d.st = arith_pkg::st_wr2;
          end
          default: begin
            if (q.b == 16'h0000) begin
              fail = 1'b1;
            end else begin
              quo = q.a / q.b;
              rem = q.a % q.b;
              mem_we = 1'b1;
              mem_wd = quo;
              d.hi = rem;
              d.flg.zero_result_flag = (quo == 16'h0000) && (rem == 16'h0000);
              d.flg.negative_flag = quo[15];
              d.st = arith_pkg::st_wr2;
            end
          end
        endcase
        if (q.cfg.op == arith_pkg::word_add_op || q.cfg.op == arith_pkg::word_subtract_op) begin
          mem_we = 1'b1;
          mem_wd = s17[15:0];
          d.flg.signed_overflow_flag = !ss[17] && (ss[16:15] != 2'b00);
          d.flg.signed_underflow_flag = ss[17] && (ss[16:15] != 2'b11);
          d.flg.zero_result_flag = (s17[15:0] == 16'h0000);
          d.flg.negative_flag = s17[15];
          ev_done = 1'b1;
        end
      end
      arith_pkg::st_wr2: begin
        mem_we = 1'b1;
        mem_wa = q.adr_r + 16'h0001;
        mem_wd = q.hi;
        d.st = arith_pkg::st_idle;
        ev_done = 1'b1;
      end
      default: begin
      end
    endcase
    if (fail) begin
      d.flg.error_flag = 1'b1;
      d.st = arith_pkg::st_idle;
      ev_err = 1'b1;
      ev_done = 1'b1;
    end

    // one wait state: answer is prepared in the first access cycle
    d.pready = acc && !q.pready;
    if (acc && !q.pready) begin
      if (i_paddr == `REG_CTRL) begin
        rdv = {10'h000, q.cfg};
      end else if (i_paddr == `REG_SRC_A) begin
        rdv = q.adr_a;
      end else if (i_paddr == `REG_SRC_B) begin
        rdv = q.adr_b;
      end else if (i_paddr == `REG_DST) begin
        rdv = q.adr_r;
      end else if (i_paddr == `REG_FLAGS) begin
        rdv = {10'h000, q.flg};
      end else if (i_paddr == `REG_STATUS) begin
        rdv = {15'h0000, busy};
      end else if (i_paddr == `REG_IRQ_STAT) begin
        rdv = {14'h0000, q.irq_st};
      end else if (i_paddr == `REG_IRQ_MASK) begin
        rdv = {14'h0000, q.irq_mask};
      end else if (i_paddr == `REG_MEM_ADDR) begin
        rdv = q.mem_addr;
      end else if (i_paddr == `REG_MEM_DATA) begin
        rdv = mem_rd;
        bad = busy || q.mem_addr >= DEPTH_W;
      end else begin
        bad = 1'b1;
      end
      // the sequencer owns memory and operands until it is idle again
      if (busy && i_pwrite && i_paddr != `REG_IRQ_STAT && i_paddr != `REG_IRQ_MASK) begin
        bad = 1'b1;
      end
      d.pslverr = bad;
      d.prdata = (i_pwrite || bad) ? 32'h00000000 : {16'h0000, rdv};
    end

    if (wr) begin
      if (i_paddr == `REG_CTRL) begin
        d.cfg = arith_pkg::cfg_t'(i_pwdata[5:0]);
        if (i_pwdata[`CTRL_GO_BIT]) begin
          if (!i_pwdata[`CTRL_COND_BIT]) begin
            ev_done = 1'b1;
          end else begin
            d.flg.error_flag = 1'b0;
            d.idx = 2'd0;
            d.st = arith_pkg::st_ptr;
          end
        end
      end else if (i_paddr == `REG_SRC_A) begin
        d.adr_a = i_pwdata[15:0];
      end else if (i_paddr == `REG_SRC_B) begin
        d.adr_b = i_pwdata[15:0];
      end else if (i_paddr == `REG_DST) begin
        d.adr_r = i_pwdata[15:0];
      end else if (i_paddr == `REG_FLAGS) begin
        d.flg.carry_flag = i_pwdata[`FLAGS_CARRY_BIT];
      end else if (i_paddr == `REG_IRQ_STAT) begin
        w1c = i_pwdata[1:0];
      end else if (i_paddr == `REG_IRQ_MASK) begin
        d.irq_mask = i_pwdata[1:0];
      end else if (i_paddr == `REG_MEM_ADDR) begin
        d.mem_addr = i_pwdata[15:0];
      end else if (i_paddr == `REG_MEM_DATA) begin
        mem_we = 1'b1;
        mem_wd = i_pwdata[15:0];
      end
    end
    // a new event beats a clear in the same cycle
    d.irq_st = (q.irq_st & ~w1c) | {ev_err, ev_done};
    d.irq = |(d.irq_st & d.irq_mask);
    // registered copy so the pin never glitches on a state change
    d.busy = (d.st != arith_pkg::st_idle);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_prdata = q.prdata;
  assign o_pready = q.pready;
  assign o_pslverr = q.pslverr;
  assign o_irq = q.irq;
  assign o_busy = q.busy;

  logic go_wr, ex_add, ex_sub, ex_div;
  logic [31:0] chk_sum, chk_prod;
  logic signed [31:0] chk_sadd, chk_ssub;
  logic chk_bor;
  logic mem_wdata_ok;
  assign mem_wdata_ok = mem_wd == chk_sum[15:0] && mem_wa == q.adr_r;
  assign go_wr = i_psel && i_penable && q.pready && i_pwrite && !q.pslverr
               && i_paddr == `REG_CTRL && i_pwdata[`CTRL_GO_BIT];
  assign ex_add = q.st == arith_pkg::st_exec && q.cfg.op == arith_pkg::word_add_op;
  assign ex_sub = q.st == arith_pkg::st_exec && q.cfg.op == arith_pkg::word_subtract_op;
  assign ex_div = q.st == arith_pkg::st_exec && q.cfg.op == arith_pkg::word_divide_op;
  assign chk_sum = 32'(q.a) + 32'(q.b) + 32'(q.flg.carry_flag);
  assign chk_prod = 32'(q.a) * 32'(q.b);
  assign chk_sadd = 32'($signed(q.a)) + 32'($signed(q.b)) + 32'(q.flg.carry_flag);
  assign chk_ssub = 32'($signed(q.a)) - 32'($signed(q.b)) - 32'(q.flg.carry_flag);
  assign chk_bor = 17'(q.b) + 17'(q.flg.carry_flag) > 17'(q.a);

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);

  property p_skip;
    go_wr && !i_pwdata[`CTRL_COND_BIT] |=> o_busy == 1'b0 && $stable(q.flg) && !mem_we;
  endproperty
  a_skip: assert property (p_skip) else $error("false condition changed state");
  property p_add_sum;
    ex_add |-> mem_we && mem_wdata_ok ##1 q.flg.carry_flag == ($past(chk_sum) > 32'h0000ffff);
  endproperty
  a_add_sum: assert property (p_add_sum) else $error("add result or carry wrong");
  property p_add_ov;
    ex_add |=> q.flg.signed_overflow_flag == ($past(chk_sadd) > 32767);
  endproperty
  a_add_ov: assert property (p_add_ov) else $error("overflow flag wrong");
  property p_sub_uf;
    ex_sub |=> q.flg.signed_underflow_flag == ($past(chk_ssub) < -32768);
  endproperty
  a_sub_uf: assert property (p_sub_uf) else $error("underflow flag wrong");
  property p_zero;
    ex_add || ex_sub |=> q.flg.zero_result_flag == ($past(mem_wd) == 16'h0000);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");
  property p_neg;
    ex_add || ex_sub |=> q.flg.negative_flag == $past(mem_wd[15]);
  endproperty
  a_neg: assert property (p_neg) else $error("negative flag wrong");
  property p_ptr_err;
    q.st == arith_pkg::st_pchk && !bcd_ok(mem_rd) |=> q.flg.error_flag && !o_busy;
  endproperty
  a_ptr_err: assert property (p_ptr_err) else $error("bad pointer not flagged");
  property p_sub_res;
    ex_sub |-> mem_we && mem_wd == 16'(chk_ssub);
  endproperty
  a_sub_res: assert property (p_sub_res) else $error("difference wrong");
  property p_borrow;
    ex_sub ##1 1'b1 |-> q.flg.carry_flag == $past(chk_bor);
  endproperty
  a_borrow: assert property (p_borrow) else $error("borrow wrong");
  property p_mul_hi;
    q.st == arith_pkg::st_wr2 && q.cfg.op == arith_pkg::word_multiply_op
      |-> mem_we && mem_wd == chk_prod[31:16] && q.flg.negative_flag == chk_prod[31];
  endproperty
  a_mul_hi: assert property (p_mul_hi) else $error("product high word wrong");
  property p_div_rem;
    ex_div && q.b != 16'h0000 |-> mem_wd == q.a / q.b ##1 mem_we && mem_wd == q.a % q.b;
  endproperty
  a_div_rem: assert property (p_div_rem) else $error("quotient or remainder wrong");
  property p_div_neg;
    ex_div && q.b != 16'h0000 |=> q.flg.negative_flag == $past(mem_wd[15]);
  endproperty
  a_div_neg: assert property (p_div_neg) else $error("quotient sign wrong");
  property p_div_zero;
    ex_div && q.b == 16'h0000 |-> !mem_we ##1 q.flg.error_flag && !mem_we && !o_busy;
  endproperty
  a_div_zero: assert property (p_div_zero) else $error("divide by zero wrote");

endmodule

`default_nettype wire

// ===== bench/seq_host.sv
`timescale 1ns/1ps
`default_nettype none

// sequencer side of the register bus; one transfer at a time
module seq_host (
  input wire logic i_clk,
  input wire logic i_ready,
  input wire logic i_err,
  input wire logic [31:0] i_rdata,
  output logic o_sel,
  output logic o_en,
  output logic o_wr,
  output logic [11:0] o_addr,
  output logic [31:0] o_wdata
);
  initial begin
    o_sel = 1'b0;
    o_en = 1'b0;
    o_wr = 1'b0;
    o_addr = 12'hfff;
    o_wdata = 32'h0;
  end

  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic err);
    @(posedge i_clk);
    o_sel <= 1'b1;
    o_en <= 1'b0;
    o_wr <= wr;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clk);
    o_en <= 1'b1;
    do @(posedge i_clk); while (i_ready !== 1'b1);
    rd = i_rdata;
    err = i_err;
    o_sel <= 1'b0;
    o_en <= 1'b0;
    // released lines flip so a stale value never looks valid
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask
endmodule

`default_nettype wire

// ===== bench/binary_word_arith_unit_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "arith_regs.svh"
`define CHK(NM, EXP, GOT) begin n_checks++; if ((GOT) !== (EXP)) begin n_errors++; \
  $display("FAIL %s exp %h got %h", NM, EXP, GOT); end end

module binary_word_arith_unit_bench;
  localparam int DEPTH = 64;
  typedef struct packed {
    logic [31:0] e;
    logic [31:0] m;
    logic err;
  } note_t;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, irq, busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  int n_errors = 0;
  int n_checks = 0;
  integer seed = 49486;
  note_t notes[$];
  note_t cur;
  arith_pkg::flags_t flg;
  logic [1:0] msk;

  always #5 i_clk = ~i_clk;

  binary_word_arith_unit #(.DEPTH(DEPTH)) i_dut (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_irq(irq), .o_busy(busy));

  seq_host i_host (.i_clk(i_clk), .i_ready(pready), .i_err(pslverr), .i_rdata(prdata),
    .o_sel(psel), .o_en(penable), .o_wr(pwrite), .o_addr(paddr), .o_wdata(pwdata));

  // oldest note answers the transfer that completes now
  always @(posedge i_clk) begin
    if (psel && penable && pready === 1'b1) begin
      cur = notes.pop_front();
      `CHK("prdata", cur.e, prdata & cur.m)
      `CHK("pslverr", cur.err, pslverr)
    end
  end

  task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] d,
      input logic [31:0] e, input logic [31:0] m, input logic err, output logic [31:0] rd);
    logic x;
    notes.push_back('{e, m, err});
    i_host.xfer(wr, a, d, rd, x);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, 32'h0, 32'h0, 1'b0, q);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    acc(1'b0, a, 32'h0, e, 32'hffffffff, 1'b0, q);
  endtask

  task automatic mwr(input logic [15:0] a, input logic [15:0] d);
    wr(`REG_MEM_ADDR, {16'h0, a});
    wr(`REG_MEM_DATA, {16'h0, d});
  endtask

  task automatic mrd(input logic [15:0] a, input logic [15:0] e);
    wr(`REG_MEM_ADDR, {16'h0, a});
    rd(`REG_MEM_DATA, {16'h0, e});
  endtask

  task automatic run(input logic [1:0] op, input logic cnd, input logic [2:0] ind,
      input logic perr, input logic cin, input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    logic [31:0] p;
    logic [15:0] r0, r1;
    int sv;
    int k;
    r0 = 16'($random(seed));
    r1 = 16'($random(seed));
    wr(`REG_IRQ_STAT, 32'h3);
    repeat (3) @(posedge i_clk);
    `CHK("irq", 1'b0, irq)
    mwr(16'd10, a);
    mwr(16'd11, b);
    mwr(16'd20, r0);
    mwr(16'd21, r1);
    wr(`REG_SRC_A, ind[0] ? 32'd12 : 32'd10);
    wr(`REG_FLAGS, {31'h0, cin});
    flg.carry_flag = cin;
    wr(`REG_CTRL, {23'h0, 1'b1, 2'h0, ind, cnd, op});
    // look just after the go edge, once the busy flop has settled
    #1 `CHK("o_busy", cnd, busy)
    if (cnd) begin
      flg.error_flag = perr || (op == 2'd3 && b == 16'h0);
      if (!flg.error_flag) begin
        case (op)
          2'd0, 2'd1: begin
            s = (op == 2'd0) ? a + b + cin : a - b - cin;
            // every term signed, or the carry makes the sum unsigned
            sv = (op == 2'd0) ? int'($signed(a)) + int'($signed(b)) + int'(cin)
                              : int'($signed(a)) - int'($signed(b)) - int'(cin);
            r0 = s[15:0];
            flg.carry_flag = s[16];
            flg.zero_result_flag = (r0 == 16'h0);
            flg.negative_flag = r0[15];
            flg.signed_overflow_flag = (sv > 32767);
            flg.signed_underflow_flag = (sv < -32768);
          end
          2'd2: begin
            p = a * b;
            {r1, r0} = p;
            flg.zero_result_flag = (p == 32'h0);
            flg.negative_flag = p[31];
          end
          default: begin
            r0 = a / b;
            r1 = a % b;
            flg.zero_result_flag = (r0 == 16'h0 && r1 == 16'h0);
            flg.negative_flag = r0[15];
          end
        endcase
      end
    end
    k = 0;
    do begin
      acc(1'b0, `REG_STATUS, 32'h0, 32'h0, 32'h0, 1'b0, r);
      k++;
    end while (r[0] !== 1'b0 && k < 40);
    `CHK("busy", 1'b0, r[0])
    `CHK("o_busy", 1'b0, busy)
    mrd(16'd20, r0);
    mrd(16'd21, r1);
    rd(`REG_FLAGS, {26'h0, flg});
    rd(`REG_IRQ_STAT, {30'h0, cnd & flg.error_flag, 1'b1});
    `CHK("irq", |({cnd & flg.error_flag, 1'b1} & msk), irq)
  endtask

  task automatic conclude();
    if (n_errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    #200000;
    n_errors++;
    conclude();
  end

  initial begin
    flg = '0;
    repeat (2) @(posedge i_clk);
    i_rstn <= 1'b1;
    rd(`REG_FLAGS, 32'h0);
    rd(`REG_IRQ_MASK, 32'h0);
    acc(1'b0, 12'h040, 32'h0, 32'h0, 32'hffffffff, 1'b1, r);
    wr(`REG_SRC_B, 32'd11);
    wr(`REG_DST, 32'd20);
    // error-only mask first, so done alone must not interrupt
    msk = 2'b10;
    wr(`REG_IRQ_MASK, {30'h0, msk});
    run(2'd0, 1'b1, 3'h0, 1'b0, 1'b0, 16'h7fff, 16'h0001);
    run(2'd0, 1'b1, 3'h0, 1'b0, 1'b0, 16'h8000, 16'hffff);
    run(2'd0, 1'b1, 3'h0, 1'b0, 1'b0, 16'ha6e2, 16'h80c5);
    run(2'd0, 1'b1, 3'h0, 1'b0, 1'b1, 16'hffff, 16'h0000);
    run(2'd1, 1'b1, 3'h0, 1'b0, 1'b0, 16'h7544, 16'hc47a);
    run(2'd1, 1'b1, 3'h0, 1'b0, 1'b0, 16'h8ad0, 16'h0bb8);
    run(2'd1, 1'b1, 3'h0, 1'b0, 1'b1, 16'h0005, 16'h0005);
    run(2'd2, 1'b1, 3'h0, 1'b0, 1'b0, 16'hffff, 16'hffff);
    run(2'd3, 1'b1, 3'h0, 1'b0, 1'b0, 16'h10f7, 16'h0003);
    run(2'd3, 1'b1, 3'h0, 1'b0, 1'b0, 16'h8000, 16'h0000);
    run(2'd3, 1'b0, 3'h0, 1'b0, 1'b1, 16'h1234, 16'h0000);
    mwr(16'd12, 16'h0010);
    run(2'd1, 1'b1, 3'h1, 1'b0, 1'b0, 16'h0003, 16'h0009);
    mwr(16'd12, 16'h001a);
    run(2'd0, 1'b1, 3'h1, 1'b1, 1'b0, 16'h0001, 16'h0001);
    mwr(16'd12, 16'h0099);
    run(2'd2, 1'b1, 3'h1, 1'b1, 1'b0, 16'h0002, 16'h0002);
    for (int i = 0; i < 20; i++) begin
      if (i == 10) begin
        msk = 2'b11;
        wr(`REG_IRQ_MASK, {30'h0, msk});
      end
      r = $random(seed);
      run(r[1:0], (i % 5) != 0, 3'h0, 1'b0, r[2], 16'($random(seed)),
          16'($random(seed)));
    end
    conclude();
  end
endmodule

`default_nettype wire
